// File: hdl/mdp_pkg.sv
// Function
// - frame opens with 32 ones, 01, opcode
// - phy address 00AAA, register address, 16 data
// - read turnaround Z0, write turnaround 10
// - strapped phy address 0h to 7h
// - 32 direct registers, some reach extended space
// - broadcast enable also accepts address 0
// - controller may broadcast one write to all
// - drive bit selects open-drain or push-pull
// - extended access takes four ordered steps
// - clock skew at index 8, device 2
// - four-bit skews reset to 0111
// - 0x03FF sets both clock skews maximal
// - irq enables high byte, flags low byte
// - reading irq register clears all flags but those with an event in the clearing cycle
// - irq pin asserts, polarity selectable, low default
// - basic control bit 11 powers down
package mdp_pkg;
  // ************************************************
  // frame layout
  // ************************************************
  localparam logic [5:0] PRE_LEN   = 6'h20;
  localparam logic [5:0] HDR_LAST  = 6'h0d;
  localparam logic [5:0] TA_LAST   = 6'h01;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  localparam logic [5:0] FR_LAST   = 6'h3f;
  localparam logic [5:0] FR_REL    = 6'h2d;
  localparam logic [5:0] FR_RDDATA = 6'h30;
  localparam logic [1:0] SOF       = 2'h1;
  localparam logic [1:0] OP_RD     = 2'h2;
  localparam logic [1:0] OP_WR     = 2'h1;
  localparam logic [1:0] TA_WR     = 2'h2;
  localparam logic [1:0] TA_RD     = 2'h3;
  localparam logic [1:0] PHY_HI    = 2'h0;
  localparam logic [4:0] PHY_BCAST = 5'h00;
  localparam logic [31:0] PREAMBLE = 32'hffffffff;
  // ************************************************
  // device register map
  // ************************************************
  localparam logic [4:0] RA_BASIC  = 5'h00;
  localparam logic [4:0] RA_XCTL   = 5'h0d;
  localparam logic [4:0] RA_XDATA  = 5'h0e;
  localparam logic [4:0] RA_COMMON = 5'h14;
  localparam logic [4:0] RA_IRQ    = 5'h1b;
  localparam logic [4:0] RA_DRIVE  = 5'h1c;
  localparam logic [4:0] RA_IRQCTL = 5'h1f;
  localparam int PWRDN_BIT  = 11;
  localparam int BCAST_BIT  = 0;
  localparam int PUSH_BIT   = 0;
  localparam int IRQPOL_BIT = 14;
  localparam int IRQ_N      = 8;
  localparam int STRAP_W    = 3;
  localparam logic [15:0] BASIC_RST = 16'h1140;
  localparam logic [1:0] XFN_ADDR  = 2'h0;
  localparam logic [4:0] XDEV_PAD  = 5'h02;
  localparam logic [15:0] XIDX_CTL = 16'h0004;
  localparam logic [15:0] XIDX_CLK = 16'h0008;
  localparam int CLK_SKEW_W = 5;
  localparam int CTL_SKEW_W = 4;
  localparam logic [9:0] CLK_SKEW_RST = 10'h0e7;
  localparam logic [7:0] CTL_SKEW_RST = 8'h77;
  // ************************************************
  // controller register map and timing
  // ************************************************
  localparam logic [7:0] HA_CMD   = 8'h00;
  localparam logic [7:0] HA_STAT  = 8'h04;
  localparam logic [7:0] HA_RDATA = 8'h08;
  localparam int CMD_RA_LSB = 16;
  localparam int CMD_PA_LSB = 21;
  localparam int CMD_RD_BIT = 26;
  localparam int CLK_NS     = 25;
  localparam int MDC_NS     = 200;
  localparam int MDC_HALF_CYC = MDC_NS / (2 * CLK_NS);
  typedef enum logic [3:0] {
    DS_PRE  = 4'b0001,
    DS_HDR  = 4'b0010,
    DS_TA   = 4'b0100,
    DS_DATA = 4'b1000
  } mdp_dstate_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_RUN  = 2'b10
  } mdp_hstate_t;
endpackage : mdp_pkg

// File: hdl/mdp_if.sv
`timescale 1ns/1ps
interface mdp_if;
  logic mdc;
  logic dev_o;
  logic dev_oe;
  logic host_o;
  logic host_oe;
  logic int_pin;
  logic mdio;
  // ************************************************
  // pulled-up shared data line
  // ************************************************
  assign mdio = ~((dev_oe & ~dev_o) | (host_oe & ~host_o));
  modport dev  (input mdc, input mdio, output dev_o, output dev_oe,
                output int_pin);
  modport host (output mdc, input mdio, output host_o,
                output host_oe, input int_pin);
endinterface : mdp_if

// File: hdl/mdp_dev_end.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module mdp_dev_end (
  input  wire logic                            REF_CLK,
  input  wire logic                            RST,
  input  wire logic [mdp_pkg::STRAP_W-1:0]     PHY_ADDR_STRAP,
  input  wire logic [mdp_pkg::IRQ_N-1:0]       EVENTS,
  output logic                                 POWER_DOWN,
  output logic [2*mdp_pkg::CLK_SKEW_W-1:0]     CLK_SKEW,
  output logic [2*mdp_pkg::CTL_SKEW_W-1:0]     CTRL_SKEW,
  mdp_if.dev                                   LINK
);
  import mdp_pkg::*;

  logic                 mdc_s1_reg, mdc_s2_reg, mdc_s3_reg;
  logic                 dio_s1_reg, dio_s2_reg;
  logic [STRAP_W-1:0]   strap_s1_reg, strap_s2_reg, phy_addr_strap_reg;
  mdp_dstate_t          st_reg;
  logic [5:0]           cnt_reg;
  logic [15:0]          sh_reg, tx_reg, basic_reg, xctl_reg, xidx_reg;
  logic [4:0]           ra_reg;
  logic                 rd_reg;
  logic [9:0]           clk_skew_reg;
  logic [7:0]           ctl_skew_reg;
  logic [IRQ_N-1:0]     irq_en_reg, irq_flag_reg;
  logic                 irq_pol_reg, broadcast_addr_enable_reg, push_reg;
  logic                 int_reg, dio_o_reg, dio_oe_reg, en_reg, val_reg;
  logic                 en_next, val_next;
  logic                 rise, hdr_end, match, take, wr_fire, tx_shift;
  logic [13:0]          hdr;
  logic [15:0]          wd;

  // ************************************************
  // extended register space helpers
  // ************************************************
  function automatic logic ext_hit(input logic [15:0] ctl,
                                   input logic [15:0] idx,
                                   input logic [15:0] want);
    ext_hit = (ctl[4:0] == XDEV_PAD) && (idx == want);
  endfunction : ext_hit

  function automatic logic [15:0] rd_mux(input logic [4:0] ra);
    rd_mux = 16'h0000;
    case (ra)
      RA_BASIC:  rd_mux = basic_reg;
      RA_XCTL:   rd_mux = xctl_reg;
      RA_XDATA: begin
        if (xctl_reg[15:14] == XFN_ADDR) rd_mux = xidx_reg;
        else if (ext_hit(xctl_reg, xidx_reg, XIDX_CLK))
          rd_mux = {6'h00, clk_skew_reg};
        else if (ext_hit(xctl_reg, xidx_reg, XIDX_CTL))
          rd_mux = {8'h00, ctl_skew_reg};
      end
      RA_COMMON: rd_mux[BCAST_BIT] = broadcast_addr_enable_reg;
      RA_IRQ:    rd_mux = {irq_en_reg, irq_flag_reg};
      RA_DRIVE:  rd_mux[PUSH_BIT] = push_reg;
      RA_IRQCTL: rd_mux[IRQPOL_BIT] = irq_pol_reg;
      default:   rd_mux = 16'h0000;
    endcase
  endfunction : rd_mux

  // ************************************************
  // pin synchronisers and strap capture
  // ************************************************
  always_ff @(posedge REF_CLK) begin
    mdc_s1_reg <= LINK.mdc;
    mdc_s2_reg <= mdc_s1_reg;
    mdc_s3_reg <= mdc_s2_reg;
    dio_s1_reg <= LINK.mdio;
    dio_s2_reg <= dio_s1_reg;
    strap_s1_reg <= PHY_ADDR_STRAP;
    strap_s2_reg <= strap_s1_reg;
  end

  // strap is only trusted while reset holds, not live
  always_ff @(posedge REF_CLK) begin
    if (RST) phy_addr_strap_reg <= strap_s2_reg;
  end

  assign rise    = mdc_s2_reg & ~mdc_s3_reg;
  assign hdr     = {sh_reg[12:0], dio_s2_reg};
  assign wd      = {sh_reg[14:0], dio_s2_reg};
  assign hdr_end = rise && (st_reg == DS_HDR) && (cnt_reg == HDR_LAST);
  assign match   = (hdr[13:12] == SOF)
                && (hdr[11:10] == OP_RD || hdr[11:10] == OP_WR)
                && (hdr[9:8] == PHY_HI)
                && ((hdr[7:5] == phy_addr_strap_reg)
                 || (broadcast_addr_enable_reg
                     && hdr[9:5] == PHY_BCAST));
  assign take    = hdr_end & match;
  assign wr_fire = rise && (st_reg == DS_DATA)
                && (cnt_reg == DATA_LAST) && !rd_reg;

  // ************************************************
  // frame state machine
  // ************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_reg  <= DS_PRE;
      cnt_reg <= 6'h00;
      sh_reg  <= 16'h0000;
      ra_reg  <= 5'h00;
      rd_reg  <= 1'b0;
    end else if (rise) begin
      sh_reg <= wd;
      case (st_reg)
        DS_PRE: begin
          if (dio_s2_reg) begin
            if (cnt_reg != PRE_LEN) cnt_reg <= cnt_reg + 6'h01;
          end else if (cnt_reg == PRE_LEN) begin
            st_reg  <= DS_HDR;
            cnt_reg <= 6'h01;
          end else begin
            cnt_reg <= 6'h00;
          end
        end
        DS_HDR: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == HDR_LAST) begin
            cnt_reg <= 6'h00;
            // foreign or malformed frames fall back to hunting
            st_reg  <= take ? DS_TA : DS_PRE;
            ra_reg  <= hdr[4:0];
            rd_reg  <= (hdr[11:10] == OP_RD);
          end
        end
        DS_TA: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == TA_LAST) begin
            st_reg  <= DS_DATA;
            cnt_reg <= 6'h00;
          end
        end
        DS_DATA: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == DATA_LAST) begin
            st_reg  <= DS_PRE;
            cnt_reg <= 6'h00;
          end
        end
        default: begin
          st_reg  <= DS_PRE;
          cnt_reg <= 6'h00;
        end
      endcase
    end
  end

  // ************************************************
  // read data and data line drive
  // ************************************************
  assign tx_shift = rise && rd_reg
                 && ((st_reg == DS_TA && cnt_reg == TA_LAST)
                  || (st_reg == DS_DATA && cnt_reg != DATA_LAST));

  always_ff @(posedge REF_CLK) begin
    if (RST) tx_reg <= 16'h0000;
    else if (take && hdr[11:10] == OP_RD) tx_reg <= rd_mux(hdr[4:0]);
    else if (tx_shift) tx_reg <= {tx_reg[14:0], 1'b0};
  end

  always_comb begin
    en_next  = en_reg;
    val_next = val_reg;
    if (rise) begin
      en_next  = 1'b0;
      val_next = 1'b1;
      if (rd_reg && st_reg == DS_TA && cnt_reg != TA_LAST) begin
        en_next  = 1'b1;
        val_next = 1'b0;
      end else if (tx_shift) begin
        en_next  = 1'b1;
        val_next = tx_reg[15];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_reg     <= 1'b0;
      val_reg    <= 1'b1;
      dio_o_reg  <= 1'b0;
      dio_oe_reg <= 1'b0;
    end else begin
      en_reg     <= en_next;
      val_reg    <= val_next;
      // open-drain only pulls low; high comes from the pull-up
      dio_o_reg  <= push_reg & val_next;
      dio_oe_reg <= en_next & (push_reg | ~val_next);
    end
  end

  // ************************************************
  // register writes
  // ************************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      basic_reg    <= BASIC_RST;
      xctl_reg     <= 16'h0000;
      xidx_reg     <= 16'h0000;
      clk_skew_reg <= CLK_SKEW_RST;
      ctl_skew_reg <= CTL_SKEW_RST;
      irq_en_reg   <= '0;
      irq_pol_reg  <= 1'b0;
      broadcast_addr_enable_reg <= 1'b0;
      push_reg     <= 1'b0;
    end else if (wr_fire) begin
      case (ra_reg)
        RA_BASIC:  basic_reg <= wd;
        RA_XCTL:   xctl_reg  <= wd;
        RA_XDATA: begin
          if (xctl_reg[15:14] == XFN_ADDR) xidx_reg <= wd;
          else if (ext_hit(xctl_reg, xidx_reg, XIDX_CLK))
            clk_skew_reg <= wd[9:0];
          else if (ext_hit(xctl_reg, xidx_reg, XIDX_CTL))
            ctl_skew_reg <= wd[7:0];
        end
        RA_COMMON: broadcast_addr_enable_reg <= wd[BCAST_BIT];
        RA_IRQ:    irq_en_reg  <= wd[15:8];
        RA_DRIVE:  push_reg    <= wd[PUSH_BIT];
        RA_IRQCTL: irq_pol_reg <= wd[IRQPOL_BIT];
        default:   xctl_reg    <= xctl_reg;
      endcase
    end
  end

  // ************************************************
  // interrupt flags and pin
  // ************************************************
  // a new event in the clearing cycle survives the clear
  always_ff @(posedge REF_CLK) begin
    if (RST) irq_flag_reg <= '0;
    else if (take && hdr[11:10] == OP_RD && hdr[4:0] == RA_IRQ)
      irq_flag_reg <= EVENTS;
    else irq_flag_reg <= irq_flag_reg | EVENTS;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) int_reg <= 1'b1;
    else int_reg <= irq_pol_reg ~^ (|(irq_flag_reg & irq_en_reg));
  end

  assign LINK.dev_o    = dio_o_reg;
  assign LINK.dev_oe   = dio_oe_reg;
  assign LINK.int_pin  = int_reg;
  assign POWER_DOWN    = basic_reg[PWRDN_BIT];
  assign CLK_SKEW      = clk_skew_reg;
  assign CTRL_SKEW     = ctl_skew_reg;
endmodule : mdp_dev_end

// File: hdl/mdp_host_end.sv
`timescale 1ns/1ps
module mdp_host_end #(
  parameter int MDC_HALF = mdp_pkg::MDC_HALF_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  mdp_if.host              LINK
);
  import mdp_pkg::*;

  mdp_hstate_t   st_reg;
  logic [7:0]    div_reg;
  logic [5:0]    idx_reg;
  logic [63:0]   fr_reg;
  logic [15:0]   rd_sh_reg, rdata_reg;
  logic          rd_reg, mdc_reg, o_reg, oe_reg;
  logic          dio_s1_reg, dio_s2_reg, int_s1_reg, int_s2_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg, pslverr_reg;
  logic          tick, start, mapped;
  logic [63:0]   frame;

  // ************************************************
  // apb slave, one wait state
  // ************************************************
  assign mapped = (PADDR == HA_CMD) || (PADDR == HA_STAT)
               || (PADDR == HA_RDATA);
  assign start  = PSEL && PENABLE && pready_reg && PWRITE
               && (PADDR == HA_CMD) && (st_reg == HS_IDLE);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= PSEL & PENABLE & ~pready_reg;
      pslverr_reg <= PSEL & PENABLE & ~pready_reg & ~mapped;
      prdata_reg  <= 32'h00000000;
      if (PSEL && PENABLE && !pready_reg && !PWRITE) begin
        if (PADDR == HA_STAT)
          prdata_reg <= {30'h0, int_s2_reg, st_reg == HS_RUN};
        else if (PADDR == HA_RDATA)
          prdata_reg <= {16'h0000, rdata_reg};
      end
    end
  end

  // ************************************************
  // frame engine
  // ************************************************
  assign tick  = (div_reg == 8'(MDC_HALF - 1));
  assign frame = {PREAMBLE, SOF,
                  PWDATA[CMD_RD_BIT] ? OP_RD : OP_WR,
                  PWDATA[CMD_PA_LSB +: 5],
                  PWDATA[CMD_RA_LSB +: 5],
                  PWDATA[CMD_RD_BIT] ? TA_RD : TA_WR,
                  PWDATA[15:0]};

  always_ff @(posedge REF_CLK) begin
    dio_s1_reg <= LINK.mdio;
    dio_s2_reg <= dio_s1_reg;
    int_s1_reg <= LINK.int_pin;
    int_s2_reg <= int_s1_reg;
  end

  // commands arriving while busy are dropped, not queued
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_reg    <= HS_IDLE;
      div_reg   <= 8'h00;
      idx_reg   <= 6'h00;
      fr_reg    <= 64'h0;
      rd_reg    <= 1'b0;
      mdc_reg   <= 1'b0;
      o_reg     <= 1'b1;
      oe_reg    <= 1'b0;
      rd_sh_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      case (st_reg)
        HS_IDLE: begin
          if (start) begin
            st_reg  <= HS_RUN;
            div_reg <= 8'h00;
            idx_reg <= 6'h00;
            fr_reg  <= frame;
            rd_reg  <= PWDATA[CMD_RD_BIT];
            o_reg   <= frame[63];
            oe_reg  <= 1'b1;
          end
        end
        HS_RUN: begin
          div_reg <= tick ? 8'h00 : div_reg + 8'h01;
          if (tick && !mdc_reg) begin
            mdc_reg <= 1'b1;
            if (rd_reg && idx_reg >= FR_RDDATA)
              rd_sh_reg <= {rd_sh_reg[14:0], dio_s2_reg};
          end else if (tick) begin
            mdc_reg <= 1'b0;
            if (idx_reg == FR_LAST) begin
              st_reg <= HS_IDLE;
              oe_reg <= 1'b0;
              o_reg  <= 1'b1;
              if (rd_reg) rdata_reg <= rd_sh_reg;
            end else begin
              idx_reg <= idx_reg + 6'h01;
              fr_reg  <= {fr_reg[62:0], 1'b0};
              o_reg   <= fr_reg[62];
              oe_reg  <= !(rd_reg && idx_reg >= FR_REL);
            end
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end

  assign PRDATA       = prdata_reg;
  assign PREADY       = pready_reg;
  assign PSLVERR      = pslverr_reg;
  assign LINK.mdc     = mdc_reg;
  assign LINK.host_o  = o_reg;
  assign LINK.host_oe = oe_reg;
endmodule : mdp_host_end

// File: verif/mdp_link_properties.sv
`timescale 1ns/1ps
module mdp_link_properties #(
  parameter int MDC_HALF = mdp_pkg::MDC_HALF_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic mdc,
  input wire logic mdio,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic host_o,
  input wire logic host_oe
);
  import mdp_pkg::*;
  localparam int MDC_PER = 2 * MDC_HALF;
  logic       mdc_q;
  logic       oe_q;
  logic       rise;
  logic [6:0] bit_cnt;
  logic [7:0] hi_cnt;
  assign rise = mdc & ~mdc_q;
  always_ff @(posedge REF_CLK) begin
    mdc_q <= RST ? 1'b0 : mdc;
    oe_q  <= RST ? 1'b0 : host_oe;
  end
  // bit index within the frame; saturates so idle never wraps
  always_ff @(posedge REF_CLK) begin
    if (RST || (host_oe && !oe_q)) begin
      bit_cnt <= 7'h00;
    end else if (rise && bit_cnt != 7'h7f) begin
      bit_cnt <= bit_cnt + 7'h01;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST || !mdc) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hff) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end
  // ****************************************
  // link properties
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_no_clash;
    dev_oe |-> !host_oe;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the line");
  property p_ta_zero;
    $rose(dev_oe) |-> !dev_o;
  endproperty
  a_ta_zero: assert property (p_ta_zero)
    else $error("device turnaround not zero");
  property p_preamble;
    rise && host_oe && bit_cnt < 7'h20 |-> mdio;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("preamble bit low");
  property p_start;
    rise && host_oe && bit_cnt == 7'h20 |-> !mdio ##MDC_PER (rise && mdio);
  endproperty
  a_start: assert property (p_start)
    else $error("bad start pattern");
  property p_write_ta;
    rise && host_oe && bit_cnt == 7'h2e |->
      mdio ##MDC_PER (rise && host_oe && !mdio);
  endproperty
  a_write_ta: assert property (p_write_ta)
    else $error("bad write turnaround");
  // ignored reads leave the line pulled up, so only a driving device counts
  property p_read_ta;
    rise && !host_oe && dev_oe && bit_cnt == 7'h2f |-> !mdio && !dev_o;
  endproperty
  a_read_ta: assert property (p_read_ta)
    else $error("read turnaround not zero");
  property p_dev_window;
    dev_oe |-> bit_cnt >= 7'h2f && bit_cnt <= 7'h40;
  endproperty
  a_dev_window: assert property (p_dev_window)
    else $error("device drives outside its bits");
  property p_mdc_high;
    $fell(mdc) |-> hi_cnt == 8'(MDC_HALF);
  endproperty
  a_mdc_high: assert property (p_mdc_high)
    else $error("clock high time wrong");
  property p_host_at_fall;
    host_oe && $past(host_oe) && $changed(host_o) |-> $fell(mdc);
  endproperty
  a_host_at_fall: assert property (p_host_at_fall)
    else $error("host data moved off clock fall");
endmodule : mdp_link_properties

// File: verif/mdp_phy_mgmt_serial_port_bench.sv
`timescale 1ns/1ps
module mdp_phy_mgmt_serial_port_bench;
  import mdp_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, pwr_dn, pol, e, act;
  logic [31:0] pwdata, prdata, seed, r;
  logic [15:0] v;
  logic [15:0] mreg [32];
  logic [9:0]  clk_skew;
  logic [7:0]  paddr, events, ctl_skew, en, ev;
  logic [2:0]  strap;
  logic [4:0]  me;
  int          error_cnt, n_checks, cyc, hi_drv;
  mdp_if mdp_if_inst ();
  mdp_dev_end mdp_dev_end_inst (.REF_CLK(clk), .RST(rst),
    .PHY_ADDR_STRAP(strap), .EVENTS(events), .POWER_DOWN(pwr_dn),
    .CLK_SKEW(clk_skew), .CTRL_SKEW(ctl_skew), .LINK(mdp_if_inst));
  mdp_host_end #(.MDC_HALF(MDC_HALF_CYC)) mdp_host_end_inst (
    .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(mdp_if_inst));
  mdp_link_properties #(.MDC_HALF(MDC_HALF_CYC)) mdp_link_properties_inst (
    .REF_CLK(clk), .RST(rst), .mdc(mdp_if_inst.mdc),
    .mdio(mdp_if_inst.mdio), .dev_o(mdp_if_inst.dev_o),
    .dev_oe(mdp_if_inst.dev_oe), .host_o(mdp_if_inst.host_o),
    .host_oe(mdp_if_inst.host_oe));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // busy is polled; the watchdog bounds a frame that never ends
  task automatic frame(input logic rd, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] q16);
    logic [31:0] q;
    logic        er;
    apb(1'b1, HA_CMD, {5'h00, rd, pa, ra, wd}, q, er);
    do apb(1'b0, HA_STAT, 32'h0, q, er); while (q[0] !== 1'b0);
    apb(1'b0, HA_RDATA, 32'h0, q, er);
    q16 = q[15:0];
  endtask : frame
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    frame(1'b0, me, ra, d, v);
    mreg[ra] = d;
  endtask : wr
  task automatic rd_chk(input string what, input logic [4:0] ra,
                        input logic [15:0] m);
    frame(1'b1, me, ra, 16'h0000, v);
    check(what, mreg[ra] & m, v & m);
    if (ra == RA_IRQ) mreg[ra][7:0] = 8'h00;
  endtask : rd_chk
  task automatic ext(input logic [15:0] idx, input logic rd,
                     input logic [15:0] d);
    frame(1'b0, me, RA_XCTL, 16'h0002, v);
    frame(1'b0, me, RA_XDATA, idx, v);
    frame(1'b0, me, RA_XCTL, 16'h4002, v);
    frame(rd, me, RA_XDATA, d, v);
  endtask : ext
  // strap is captured only while reset is high
  task automatic do_rst(input logic [2:0] s);
    @(posedge clk);
    strap <= s;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (mreg[k]) mreg[k] = 16'h0000;
    mreg[RA_BASIC] = BASIC_RST;
    me = {2'b00, s};
  endtask : do_rst
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (mdp_if_inst.dev_oe && mdp_if_inst.dev_o) hi_drv++;
    if (cyc == 80000) begin
      error_cnt++;
      conclude();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 3'h0;
    events = 8'h00;
    seed = 32'h00000015;
    for (int s = 0; s < 8; s++) begin
      do_rst(s[2:0]);
      check("idle pin", 16'h0001, {15'h0, mdp_if_inst.int_pin});
      check("ctl skew", 16'h0077, {8'h00, ctl_skew});
      check("clk skew", 16'h00e7, {6'h00, clk_skew});
      rd_chk("basic", RA_BASIC, 16'hffff);
      frame(1'b1, {2'b00, strap + 3'h1}, RA_BASIC, 16'h0000, v);
      check("foreign read", 16'hffff, v);
    end
    $display("test strap done");
    r = xs();
    do_rst(r[2:0] == 3'h0 ? 3'h5 : r[2:0]);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    check("unmapped err", 16'h0001, {15'h0, e});
    rd_chk("hole", 5'h05, 16'hffff);
    ext(XIDX_CLK, 1'b1, 16'h0000);
    check("clk skew rd", 16'h00e7, v);
    ext(XIDX_CLK, 1'b0, 16'h03ff);
    check("clk skew max", 16'h03ff, {6'h00, clk_skew});
    ext(XIDX_CLK, 1'b1, 16'h0000);
    check("clk skew rd", 16'h03ff, v);
    for (int i = 0; i < 3; i++) begin
      r = xs();
      ext(XIDX_CTL, 1'b0, {8'h00, r[7:0]});
      check("ctl skew", {8'h00, r[7:0]}, {8'h00, ctl_skew});
      ext(XIDX_CTL, 1'b1, 16'h0000);
      check("ctl skew rd", {8'h00, r[7:0]}, v);
    end
    $display("test extended done");
    frame(1'b0, PHY_BCAST, RA_BASIC, 16'h1940, v);
    check("pd bcast off", 16'h0000, {15'h0, pwr_dn});
    frame(1'b0, {2'b01, strap}, RA_BASIC, 16'h1940, v);
    check("pd bad phy", 16'h0000, {15'h0, pwr_dn});
    wr(RA_COMMON, 16'h0001);
    frame(1'b0, PHY_BCAST, RA_BASIC, 16'h1940, v);
    check("pd bcast on", 16'h0001, {15'h0, pwr_dn});
    frame(1'b1, PHY_BCAST, RA_COMMON, 16'h0000, v);
    check("bcast read", 16'h0001, v & 16'h0001);
    wr(RA_BASIC, 16'h1140);
    check("pd off", 16'h0000, {15'h0, pwr_dn});
    $display("test broadcast done");
    hi_drv = 0;
    rd_chk("basic od", RA_BASIC, 16'hffff);
    check("od high", 16'h0000, hi_drv[15:0]);
    wr(RA_DRIVE, 16'h0001);
    hi_drv = 0;
    rd_chk("basic pp", RA_BASIC, 16'hffff);
    check("pp high", 16'h0001, {15'h0, hi_drv > 0});
    wr(RA_DRIVE, 16'h0000);
    $display("test drive done");
    for (int i = 0; i < 3; i++) begin
      r = xs();
      pol = (i > 0);
      ev = r[7:0] | 8'h01;
      en = (i == 2) ? ~ev : (r[15:8] | 8'h01);
      act = |(en & ev);
      wr(RA_IRQCTL, pol ? 16'h4000 : 16'h0000);
      wr(RA_IRQ, {en, 8'h00});
      @(posedge clk);
      events <= ev;
      @(posedge clk);
      events <= 8'h00;
      mreg[RA_IRQ][7:0] = ev;
      repeat (3) @(posedge clk);
      check("irq pin", {15'h0, act ~^ pol},
            {15'h0, mdp_if_inst.int_pin});
      apb(1'b0, HA_STAT, 32'h0, r, e);
      check("stat pin", {15'h0, act ~^ pol}, {15'h0, r[1]});
      rd_chk("irq", RA_IRQ, 16'hffff);
      rd_chk("irq clr", RA_IRQ, 16'hffff);
      check("pin idle", {15'h0, ~pol}, {15'h0, mdp_if_inst.int_pin});
    end
    $display("test irq done");
    conclude();
  end
endmodule : mdp_phy_mgmt_serial_port_bench
